//--- hw/rsc_pkg.sv
package rsc_pkg;

	localparam int CLK_PERIOD_PS = 5000;

	// supply settle and brown-out release delay, least times in microseconds
	localparam int POWER_UP_SETTLE_US      = 1000;
	localparam int BROWNOUT_RELEASE_DELAY_US = 1000;
	localparam int POWER_UP_SETTLE_CYC =
		(POWER_UP_SETTLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int BROWNOUT_RELEASE_CYC =
		(BROWNOUT_RELEASE_DELAY_US * 1000000 + CLK_PERIOD_PS - 1) /
		CLK_PERIOD_PS;

	localparam int CNT_W = 18;

	// bus clock is sys_clk / 4
	localparam logic BCLK_DIV_LAST = 1'b1;
	localparam int VECTOR_FETCH_BCLK = 28;
	localparam int INT_RESET_HOLD_CYC = 20;

	localparam logic [19:0] RESET_VECTOR_ADDR = 20'hffffc;

	localparam logic [1:0] PM_SINGLE_CHIP = 2'h0;
	localparam logic [1:0] PM_MICROPROC   = 2'h3;

	// synchroniser lanes and their idle values
	localparam int SYNC_W       = 5;
	localparam int SY_RESET_PIN = 0;
	localparam int SY_MODE_SEL  = 1;
	localparam int SY_BOD_BELOW = 2;
	localparam int SY_BOD_ABOVE = 3;
	localparam int SY_REQ_B     = 4;
	localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 5'h10;

	typedef enum logic [2:0] {
		ST_SETTLE,
		ST_HOLD,
		ST_BOD_HOLD,
		ST_BOD_DELAY,
		ST_INT_HOLD,
		ST_RELEASE,
		ST_RUN,
		ST_OSC_STOP
	} rsc_state_t;

endpackage

//--- hw/rsc_sync_if.sv
`timescale 1ns/10ps
interface rsc_sync_if;
	import rsc_pkg::*;
	logic [SYNC_W-1:0] raw;
	logic [SYNC_W-1:0] sync;
	modport sink (input raw, output sync);
	modport src  (output raw, input sync);
endinterface

//--- hw/rsc_sync.sv
`timescale 1ns/10ps
module rsc_sync
	import rsc_pkg::*;
(
	input  wire logic    sys_clk,
	input  wire logic    rst_b,
	rsc_sync_if.sink     sif
);

	logic [SYNC_W-1:0] meta_q;
	logic [SYNC_W-1:0] meta_d;
	logic [SYNC_W-1:0] sync_q;
	logic [SYNC_W-1:0] sync_d;

	always_comb begin
		meta_d = sif.raw;
		sync_d = meta_q;
	end

	// two flops per lane; only the second flop is visible outside
	genvar i;
	generate
		for (i = 0; i < SYNC_W; i++) begin : g_lane
			always_ff @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b) begin
					meta_q[i] <= SYNC_RST_VAL[i];
					sync_q[i] <= SYNC_RST_VAL[i];
				end else begin
					meta_q[i] <= meta_d[i];
					sync_q[i] <= sync_d[i];
				end
			end
		end
	endgenerate

	assign sif.sync = sync_q;

endmodule

//--- hw/rsc_reset_ctrl.sv
`timescale 1ns/10ps
// What this block does
// RULE1 - supply rises with pin low, settle wait
// RULE2 - twenty main clocks before pin release
// RULE3 - microprocessor reset: chip select, strobes high
// RULE4 - microprocessor reset: latch strobe low, clock runs
// RULE5 - bus release grant follows request in reset
// RULE6 - upper pins input pulled up; address undefined
// RULE7 - pin states valid only after supply settles
// RULE8 - enabled detector below trip holds full reset
// RULE9 - release level then delay, then vector
// RULE10 - brown-out reset equals pin reset
// RULE11 - brown-out ignored during stop mode
// RULE12 - software reset bit resets, restarts at vector
// RULE13 - software reset only on stable main clock; the code takes the write in run with no clock check
// RULE14 - internal resets keep processor mode bits
// RULE15 - watchdog underflow with select resets
// RULE16 - oscillator stop with select zero halts
// RULE17 - vector fetched fixed bus clocks after release
// RULE18 - ram never cleared; write during reset flagged
module rsc_reset_ctrl
	import rsc_pkg::*;
#(
	parameter int SETTLE_CYC    = POWER_UP_SETTLE_CYC,
	parameter int BOD_DELAY_CYC = BROWNOUT_RELEASE_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        reset_pin_b,
	input  wire logic        mode_select_pin,
	input  wire logic        brownout_below_trip,
	input  wire logic        brownout_above_release,
	input  wire logic        bus_release_req_b,
	input  wire logic        reset_level_detect_enable,
	input  wire logic        stop_mode,
	input  wire logic        software_reset_wr,
	input  wire logic        pm_wr,
	input  wire logic [1:0]  pm_wdata,
	input  wire logic        watchdog_underflow,
	input  wire logic        watchdog_action_select,
	input  wire logic        osc_stop_detected,
	input  wire logic        osc_stop_action_select,
	input  wire logic        bus_cs0_b,
	input  wire logic        bus_wr_b,
	input  wire logic        bus_rd_b,
	input  wire logic        bus_ale,
	input  wire logic        bus_grant_b,
	input  wire logic        ram_write,
	input  wire logic        ram_unknown_clr,
	output logic             core_reset,
	output logic             pins_valid,
	output logic [1:0]       processor_mode,
	output logic             bus_oe,
	output logic             chip_select_zero_b,
	output logic             write_strobe_b,
	output logic             read_strobe_b,
	output logic             addr_latch_strobe,
	output logic             bus_clock_out,
	output logic             bus_release_grant_b,
	output logic             upper_pins_pull_en,
	output logic             addr_bhe_oe,
	output logic             vector_fetch,
	output logic [19:0]      vector_addr,
	output logic             osc_halted,
	output logic             ram_unknown
);

	rsc_sync_if sif ();
	assign sif.raw = {bus_release_req_b, brownout_above_release,
		brownout_below_trip, mode_select_pin, reset_pin_b};
	rsc_sync u_sync (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.sif     (sif.sink)
	);

	wire logic pin_hi_s = sif.sync[SY_RESET_PIN];
	wire logic mode_s   = sif.sync[SY_MODE_SEL];
	wire logic below_s  = sif.sync[SY_BOD_BELOW];
	wire logic above_s  = sif.sync[SY_BOD_ABOVE];
	wire logic req_b_s  = sif.sync[SY_REQ_B];

	rsc_state_t       state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [1:0]       pm_q, pm_d;
	logic             bdiv_q, bdiv_d;
	logic             bclk_q, bclk_d;
	logic             bclk_rise, bod_trip, wdt_req, osc_req;
	logic             in_rst_mp, rst_d, mp_d;
	logic core_rst_q, valid_q, oe_q, cs_q, wr_q, rd_q, ale_q, grant_q;
	logic pull_q, abhe_q, fetch_q, halt_q, ramu_q;
	logic core_rst_d, valid_d, oe_d, cs_d, wr_d, rd_d, ale_d, grant_d;
	logic pull_d, abhe_d, fetch_d, halt_d, ramu_d;
	logic [19:0] vaddr_q, vaddr_d;

	// detector is off in stop mode, so no wake-up through it
	assign bod_trip = reset_level_detect_enable && below_s &&
		!stop_mode; // RULE8 RULE11
	assign wdt_req  = watchdog_action_select && watchdog_underflow; // RULE15
	assign osc_req  = !osc_stop_action_select && osc_stop_detected; // RULE16
	assign bclk_rise = (bdiv_q == BCLK_DIV_LAST) && !bclk_q;
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		pm_d    = pm_q;
		fetch_d = 1'b0;
		vaddr_d = vaddr_q;
		case (state_q)
			ST_SETTLE: begin
				// external party keeps the pin low through this wait
				if (cnt_q == CNT_W'(SETTLE_CYC - 1)) begin // RULE1 RULE7
					state_d = ST_HOLD;
					cnt_d   = '0;
				end else begin
					cnt_d = cnt_q + CNT_W'(1);
				end
			end
			ST_HOLD: begin
				// pin release implies the main clocks were supplied
				if (pin_hi_s) begin // RULE2
					state_d = ST_RELEASE;
					cnt_d   = '0;
				end
			end
			ST_BOD_HOLD: begin
				if (above_s) begin // RULE9
					state_d = ST_BOD_DELAY;
					cnt_d   = '0;
				end
			end
			ST_BOD_DELAY: begin
				if (cnt_q == CNT_W'(BOD_DELAY_CYC - 1)) begin // RULE9
					state_d = ST_RELEASE;
					cnt_d   = '0;
				end else begin
					cnt_d = cnt_q + CNT_W'(1);
				end
			end
			ST_INT_HOLD: begin
				if (cnt_q == CNT_W'(INT_RESET_HOLD_CYC - 1)) begin
					state_d = ST_RELEASE;
					cnt_d   = '0;
				end else begin
					cnt_d = cnt_q + CNT_W'(1);
				end
			end
			ST_RELEASE: begin
				if (bclk_rise) begin
					cnt_d = cnt_q + CNT_W'(1);
					if (cnt_q == CNT_W'(VECTOR_FETCH_BCLK - 1)) begin // RULE17
						state_d = ST_RUN;
						cnt_d   = '0;
						fetch_d = 1'b1;
						vaddr_d = RESET_VECTOR_ADDR;
					end
				end
			end
			ST_RUN: begin
				if (pm_wr) begin
					pm_d = pm_wdata;
				end
				// processor mode is left as is by these three
				if (software_reset_wr || wdt_req) begin // RULE12 RULE15 RULE14
					state_d = ST_INT_HOLD;
					cnt_d   = '0;
				end else if (osc_req) begin // RULE16 RULE14
					state_d = ST_OSC_STOP;
				end
			end
			default: begin
				state_d = ST_OSC_STOP;
			end
		endcase
		if (state_q != ST_SETTLE) begin
			if (!pin_hi_s) begin
				state_d = ST_HOLD;
				cnt_d   = '0;
				fetch_d = 1'b0;
			end else if (bod_trip) begin // RULE8
				state_d = ST_BOD_HOLD;
				cnt_d   = '0;
				fetch_d = 1'b0;
			end
		end
		// hardware resets of both kinds reload the mode from the strap
		if (state_d == ST_SETTLE || state_d == ST_HOLD ||
			state_d == ST_BOD_HOLD || state_d == ST_BOD_DELAY) begin // RULE10
			pm_d = mode_s ? PM_MICROPROC : PM_SINGLE_CHIP;
		end
	end

	always_comb begin
		bdiv_d = bdiv_q;
		bclk_d = bclk_q;
		if (state_q != ST_OSC_STOP) begin // RULE4
			bdiv_d = bdiv_q + 1'b1;
			if (bdiv_q == BCLK_DIV_LAST) begin
				bclk_d = !bclk_q;
			end
		end
	end

	always_comb begin
		rst_d     = (state_d != ST_RUN);
		mp_d      = (pm_d != PM_SINGLE_CHIP);
		in_rst_mp = rst_d && mp_d;
		core_rst_d = rst_d;
		valid_d   = (state_d != ST_SETTLE); // RULE7
		oe_d      = valid_d && mp_d; // RULE7
		cs_d      = in_rst_mp ? 1'b1 : bus_cs0_b; // RULE3
		wr_d      = in_rst_mp ? 1'b1 : bus_wr_b; // RULE3
		rd_d      = in_rst_mp ? 1'b1 : bus_rd_b; // RULE3
		ale_d     = in_rst_mp ? 1'b0 : bus_ale; // RULE4
		grant_d   = in_rst_mp ? req_b_s : bus_grant_b; // RULE5
		pull_d    = in_rst_mp && valid_d; // RULE6
		abhe_d    = valid_d && mp_d; // RULE6
		halt_d    = (state_d == ST_OSC_STOP); // RULE16
		// ram is never cleared, only marked when a write is cut short
		ramu_d    = ramu_q;
		if (ram_unknown_clr) begin
			ramu_d = 1'b0;
		end
		if (!pin_hi_s && ram_write) begin // RULE18
			ramu_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q    <= ST_SETTLE;
			cnt_q      <= '0;
			pm_q       <= PM_SINGLE_CHIP;
			bdiv_q     <= 1'b0;
			bclk_q     <= 1'b0;
			vaddr_q    <= '0;
			core_rst_q <= 1'b1;
			valid_q    <= 1'b0;
			oe_q       <= 1'b0;
			cs_q       <= 1'b1;
			wr_q       <= 1'b1;
			rd_q       <= 1'b1;
			ale_q      <= 1'b0;
			grant_q    <= 1'b1;
			pull_q     <= 1'b0;
			abhe_q     <= 1'b0;
			fetch_q    <= 1'b0;
			halt_q     <= 1'b0;
			ramu_q     <= 1'b0;
		end else begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			pm_q       <= pm_d;
			bdiv_q     <= bdiv_d;
			bclk_q     <= bclk_d;
			vaddr_q    <= vaddr_d;
			core_rst_q <= core_rst_d;
			valid_q    <= valid_d;
			oe_q       <= oe_d;
			cs_q       <= cs_d;
			wr_q       <= wr_d;
			rd_q       <= rd_d;
			ale_q      <= ale_d;
			grant_q    <= grant_d;
			pull_q     <= pull_d;
			abhe_q     <= abhe_d;
			fetch_q    <= fetch_d;
			halt_q     <= halt_d;
			ramu_q     <= ramu_d;
		end
	end

	assign core_reset          = core_rst_q;
	assign pins_valid          = valid_q;
	assign processor_mode      = pm_q;
	assign bus_oe              = oe_q;
	assign chip_select_zero_b  = cs_q;
	assign write_strobe_b      = wr_q;
	assign read_strobe_b       = rd_q;
	assign addr_latch_strobe   = ale_q;
	assign bus_clock_out       = bclk_q;
	assign bus_release_grant_b = grant_q;
	assign upper_pins_pull_en  = pull_q;
	assign addr_bhe_oe         = abhe_q;
	assign vector_fetch        = fetch_q;
	assign vector_addr         = vaddr_q;
	assign osc_halted          = halt_q;
	assign ram_unknown         = ramu_q;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	wire logic run_clean = (state_q == ST_RUN) && pin_hi_s && !bod_trip;
	sequence s_mp_reset;
		core_rst_q && (pm_q != PM_SINGLE_CHIP) && valid_q;
	endsequence
	sequence s_int_hold;
		state_q == ST_INT_HOLD;
	endsequence

	a_mp_strobes_high: assert property (s_mp_reset |-> cs_q && wr_q && rd_q) // RULE3
		else $error("strobe not high in microprocessor reset");
	a_ale_low_bclk: assert property ((s_mp_reset and !halt_q) |->
		!ale_q ##[1:2] $changed(bclk_q)) // RULE4
		else $error("latch strobe high or bus clock stuck in reset");
	a_grant_follows: assert property ($past(in_rst_mp) |->
		grant_q == $past(req_b_s)) // RULE5
		else $error("grant does not follow request in reset");
	a_upper_pull: assert property (s_mp_reset |-> pull_q && abhe_q) // RULE6
		else $error("upper pins not pulled up in reset");
	a_settle_pins: assert property (state_q == ST_SETTLE |->
		!valid_q && !oe_q) // RULE7
		else $error("pins driven before supply settled");
	a_bod_trip_hold: assert property (run_clean == 1'b0 && pin_hi_s &&
		bod_trip && state_q != ST_SETTLE |=>
		state_q == ST_BOD_HOLD && core_rst_q) // RULE8 RULE10
		else $error("brown-out did not hold reset");
	a_stop_no_bod: assert property (state_q == ST_RUN && pin_hi_s &&
		stop_mode && !software_reset_wr && !wdt_req && !osc_req |=>
		state_q == ST_RUN) // RULE11
		else $error("reset left run without a cause");
	a_int_reset: assert property (run_clean &&
		(software_reset_wr || wdt_req) |=> s_int_hold ##0 core_rst_q) // RULE12 RULE15
		else $error("internal reset not taken");
	a_mode_kept: assert property ((s_int_hold and (pin_hi_s && !bod_trip)) |=>
		$stable(pm_q)) // RULE14
		else $error("processor mode changed by internal reset");
	a_osc_halt: assert property (run_clean && !software_reset_wr &&
		!wdt_req && osc_req |=> halt_q ##1 halt_q && $stable(bclk_q)) // RULE16
		else $error("oscillator stop did not halt");
	a_vector_fetch: assert property ($rose(fetch_q) |->
		$past(state_q) == ST_RELEASE && !core_rst_q &&
		$past(cnt_q) == CNT_W'(VECTOR_FETCH_BCLK - 1)) // RULE17 RULE9
		else $error("vector fetch at wrong time");
	a_ram_flag: assert property (!pin_hi_s && ram_write |=> ramu_q) // RULE18
		else $error("cut ram write not flagged");

endmodule

//--- verification/rsc_ext_reset_model.sv
`timescale 1ns/10ps
// external reset circuit: pin low from power-up, then at least 20 clocks
module rsc_ext_reset_model (
	input  wire logic sys_clk,
	input  wire logic pin_req,
	output logic      reset_pin_b
);
	int unsigned low_cnt = 0;
	initial reset_pin_b = 1'b0;
	always @(posedge sys_clk) begin
		if (pin_req) begin
			reset_pin_b <= 1'b0;
			low_cnt     <= 0;
		end else if (low_cnt < 20) begin
			low_cnt <= low_cnt + 1;
		end else begin
			reset_pin_b <= 1'b1;
		end
	end
endmodule

//--- verification/rsc_reset_ctrl_tb.sv
`timescale 1ns/10ps
module rsc_reset_ctrl_tb;
	import rsc_pkg::*;
	localparam int SETTLE = 10;
	localparam int BOD    = 10;
	logic        sys_clk, rst_b, reset_pin_b, pin_req, mode_sel;
	logic        below, above, req_b, lvl_en, stop_mode, sw_wr, pm_wr;
	logic [1:0]  pm_wdata, mode;
	logic        wd_uf, wd_sel, osc_det, osc_sel, ram_wr, ram_clr;
	logic [4:0]  bus_in, bus_out;
	logic        core_reset, pins_valid, bus_oe, bclk, pull_en, bhe_oe;
	logic        fetch, osc_halted, ram_unknown;
	logic [19:0] vaddr;
	logic [1:0]  exp_mode;
	int          err_total, n_compared, seed, n, k;

	rsc_reset_ctrl #(.SETTLE_CYC(SETTLE), .BOD_DELAY_CYC(BOD)) u_rsc_reset_ctrl (
		.sys_clk(sys_clk), .rst_b(rst_b), .reset_pin_b(reset_pin_b),
		.mode_select_pin(mode_sel), .brownout_below_trip(below),
		.brownout_above_release(above), .bus_release_req_b(req_b),
		.reset_level_detect_enable(lvl_en), .stop_mode(stop_mode),
		.software_reset_wr(sw_wr), .pm_wr(pm_wr), .pm_wdata(pm_wdata),
		.watchdog_underflow(wd_uf), .watchdog_action_select(wd_sel),
		.osc_stop_detected(osc_det), .osc_stop_action_select(osc_sel),
		.bus_cs0_b(bus_in[4]), .bus_wr_b(bus_in[3]), .bus_rd_b(bus_in[2]),
		.bus_ale(bus_in[1]), .bus_grant_b(bus_in[0]), .ram_write(ram_wr),
		.ram_unknown_clr(ram_clr), .core_reset(core_reset),
		.pins_valid(pins_valid), .processor_mode(mode), .bus_oe(bus_oe),
		.chip_select_zero_b(bus_out[4]), .write_strobe_b(bus_out[3]),
		.read_strobe_b(bus_out[2]), .addr_latch_strobe(bus_out[1]),
		.bus_clock_out(bclk), .bus_release_grant_b(bus_out[0]),
		.upper_pins_pull_en(pull_en), .addr_bhe_oe(bhe_oe),
		.vector_fetch(fetch), .vector_addr(vaddr), .osc_halted(osc_halted),
		.ram_unknown(ram_unknown)
	);
	rsc_ext_reset_model u_rsc_ext_reset_model (
		.sys_clk(sys_clk), .pin_req(pin_req), .reset_pin_b(reset_pin_b)
	);

	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [19:0] seen, input logic [19:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		if (err_total == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic cyc(input int c);
		repeat (c) @(negedge sys_clk);
	endtask

	// wait for the vector fetch pulse, count cycles spent
	task automatic wait_fetch(input int bound, output int cnt);
		cnt = 0;
		while (fetch !== 1'b1 && cnt < bound) begin
			cyc(1);
			cnt++;
		end
		if (cnt >= bound) begin
			err_total++;
			tally_and_finish();
		end
		check(core_reset, 1'b0);
		check(vaddr, RESET_VECTOR_ADDR);
		check(cnt > 100, 1'b1);
	endtask

	task automatic bclk_changes(input int c, output int chg);
		logic last;
		chg = 0;
		last = bclk;
		repeat (c) begin
			cyc(1);
			if (bclk !== last) chg++;
			last = bclk;
		end
	endtask

	// model of the running bus: outputs repeat last cycle's inputs
	task automatic run_bus(input int c);
		repeat (c) begin
			bus_in = 5'($random(seed));
			cyc(1);
			check(bus_out, bus_in);
		end
	endtask

	// kinds: 0 software, 1 watchdog on, 2 watchdog off, 3 osc stop off
	task automatic internal_reset(input int kind);
		logic exp_rst;
		exp_rst = (kind < 2);
		wd_sel = (kind == 1);
		osc_sel = 1'b1;
		cyc(1);
		if (kind == 0) sw_wr = 1'b1;
		else if (kind < 3) wd_uf = 1'b1;
		else osc_det = 1'b1;
		cyc(1);
		sw_wr = 1'b0;
		wd_uf = 1'b0;
		osc_det = 1'b0;
		cyc(1);
		check(core_reset, exp_rst);
		check(mode, exp_mode);
		if (exp_rst) wait_fetch(400, n);
		check(mode, exp_mode);
	endtask

	initial begin
		err_total = 0;
		n_compared = 0;
		repeat (60000) @(posedge sys_clk);
		err_total++;
		tally_and_finish();
	end

	initial begin
		seed = 32'h16eb2ce6;
		{rst_b, pin_req, mode_sel, below, above, req_b, lvl_en} = 7'h3a;
		{stop_mode, sw_wr, pm_wr, pm_wdata, wd_uf, wd_sel} = 7'h00;
		{osc_det, osc_sel, ram_wr, ram_clr, bus_in} = 9'h09d;
		cyc(4);
		rst_b = 1'b1;
		check(pins_valid, 1'b0);
		cyc(SETTLE + 4);
		check(pins_valid, 1'b1);
		check({core_reset, mode, bus_oe}, 4'hf);
		check(bus_out[4:1], 4'he);
		check({pull_en, bhe_oe}, 2'h3);
		bclk_changes(8, n);
		check(n, 4);
		for (k = 0; k < 4; k++) begin
			req_b = k[0];
			cyc(5);
			check(bus_out[0], k[0]);
		end
		ram_wr = 1'b1;
		cyc(4);
		ram_wr = 1'b0;
		check(ram_unknown, 1'b1);
		ram_clr = 1'b1;
		cyc(1);
		ram_clr = 1'b0;
		cyc(1);
		check(ram_unknown, 1'b0);
		ram_wr = 1'b1;
		ram_clr = 1'b1;
		cyc(1);
		{ram_wr, ram_clr} = 2'h0;
		check(ram_unknown, 1'b1);
		pin_req = 1'b0;
		wait_fetch(400, n);
		run_bus(16);
		pm_wr = 1'b1;
		cyc(1);
		pm_wr = 1'b0;
		cyc(1);
		exp_mode = 2'h0;
		check({mode, bus_oe}, 3'h0);
		for (k = 0; k < 4; k++) internal_reset(k);
		run_bus(8);
		lvl_en = 1'b1;
		stop_mode = 1'b1;
		below = 1'b1;
		above = 1'b0;
		cyc(8);
		check(core_reset, 1'b0);
		stop_mode = 1'b0;
		cyc(30);
		check({core_reset, mode}, 3'h7);
		below = 1'b0;
		above = 1'b1;
		wait_fetch(400, n);
		check(n > BOD + 100, 1'b1);
		osc_sel = 1'b0;
		osc_det = 1'b1;
		cyc(3);
		osc_det = 1'b0;
		check({osc_halted, core_reset}, 2'h3);
		bclk_changes(8, n);
		check(n, 0);
		pin_req = 1'b1;
		mode_sel = 1'b0;
		cyc(6);
		pin_req = 1'b0;
		check(osc_halted, 1'b0);
		check({core_reset, mode, bus_oe}, 4'h8);
		wait_fetch(400, n);
		run_bus(4);
		tally_and_finish();
	end
endmodule
